// [core/srs_defines.vh]
// Timing constants for the supply reset supervisor
`ifndef SRS_DEFINES_VH
`define SRS_DEFINES_VH

// Clock rate in kHz and period in ps
`define SRS_CLK_KHZ 40000
`define SRS_CLK_PS 25000
// Reset timeout, nominal 200 ms, bounds 130 and 270 ms
`define SRS_RST_TIMEOUT_MS 200
`define SRS_RST_TIMEOUT_MIN_MS 130
`define SRS_RST_TIMEOUT_MAX_MS 270
`define SRS_RST_TIMEOUT_CYC (`SRS_RST_TIMEOUT_MS * `SRS_CLK_KHZ)
// Threshold to reset delay, longest 5 us
`define SRS_THR_DELAY_NS 5000
`define SRS_THR_DELAY_CYC ((`SRS_THR_DELAY_NS * 1000) / `SRS_CLK_PS)
// Supply dip reject width 30 ns (rounded up, at least one cycle)
`define SRS_DIP_REJECT_NS 30
`define SRS_DIP_REJECT_CYC (((`SRS_DIP_REJECT_NS * 1000) + `SRS_CLK_PS - 1) / `SRS_CLK_PS)
// Manual reset glitch rejection 100 ns
`define SRS_MR_GLITCH_NS 100
`define SRS_MR_GLITCH_CYC (((`SRS_MR_GLITCH_NS * 1000) + `SRS_CLK_PS - 1) / `SRS_CLK_PS)
// Program cycle time, longest 5 ms
`define SRS_PROG_CYCLE_MS 5
`define SRS_PROG_CYCLE_CYC (`SRS_PROG_CYCLE_MS * `SRS_CLK_KHZ)

`endif

// [core/srs_supervisor.v]
// Supply reset supervisor with manual reset and memory gating
// Notes on behaviour
// - Hold reset while supply is low, then for the timeout after recovery.
// - At timeout end release the open-drain reset so the pull sets it.
// - Assert reset within 5 us of the supply dropping.
// - Ignore supply dips of 30 ns or shorter.
// - A falling edge on the active-low reset pin starts a new timeout.
// - A short external reset still yields a full internal timeout.
// - Manual reset pulses under 100 ns are rejected.
// - Memory is disabled for all operations while reset is active.
// - Reset aborts a bus transaction and blocks new ones until release.
// - No program cycle starts in reset; a running one finishes.
// - A program cycle ends within 5 ms of the stop that began it.
// - During a program cycle bus_disable holds the bus off.
// - Two reset polarities; only the active-low pin doubles as input.
`timescale 1ns/1ps
`default_nettype none
`include "srs_defines.vh"

module srs_supervisor #(
  parameter ACTIVE_LOW = 1,
  parameter TIMEOUT_CYC = `SRS_RST_TIMEOUT_CYC,
  parameter PROG_CYC = `SRS_PROG_CYCLE_CYC,
  parameter DIP_CYC = `SRS_DIP_REJECT_CYC,
  parameter MR_CYC = `SRS_MR_GLITCH_CYC,
  parameter CW = 24
) (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Supply comparator
  input wire supply_good,
  // Reset pin, open drain
  input wire reset_pin_in,
  output reg reset_pin_out,
  output reg reset_pin_oe_n,
  // Memory core handshake
  input wire prog_start_req,
  input wire bus_active,
  output reg mem_enable,
  output reg bus_abort,
  output reg prog_busy,
  output reg bus_disable,
  output reg sys_reset_active
);

  // State codes, one-hot
  localparam [2:0] ST_HOLD = 3'b001;
  localparam [2:0] ST_TIMEOUT = 3'b010;
  localparam [2:0] ST_RUN = 3'b100;
  // Terminal counts, cut to counter width on purpose
  localparam integer TO_LAST_I = TIMEOUT_CYC - 1;
  localparam integer PG_LAST_I = PROG_CYC - 1;
  localparam integer DIP_I = DIP_CYC;
  localparam integer MR_I = MR_CYC;
  localparam [CW-1:0] TO_LAST = TO_LAST_I[CW-1:0];
  localparam [CW-1:0] PG_LAST = PG_LAST_I[CW-1:0];
  localparam [7:0] DIP_N = DIP_I[7:0];
  localparam [7:0] MR_N = MR_I[7:0];

  // Synchronisers
  reg sg_s1_reg, sg_s2_reg, pin_s1_reg, pin_s2_reg;
  // Filters
  reg [7:0] dip_cnt_reg, mr_cnt_reg;
  reg sg_filt_reg, pin_filt_reg, pin_filt_d_reg;
  // Sequencer
  reg [2:0] state_reg;
  reg [CW-1:0] to_cnt_reg;
  reg [CW-1:0] pg_cnt_reg;
  reg rst_act;
  wire mr_edge;

  // Two-stage synchronisers for supply-good and pin
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sg_s1_reg <= 1'b0;
      sg_s2_reg <= 1'b0;
      pin_s1_reg <= 1'b1;
      pin_s2_reg <= 1'b1;
    end else begin
      sg_s1_reg <= supply_good;
      sg_s2_reg <= sg_s1_reg;
      pin_s1_reg <= reset_pin_in;
      pin_s2_reg <= pin_s1_reg;
    end
  end

  // Supply dip filter: low must persist past dip width before it counts
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dip_cnt_reg <= 8'h00;
      sg_filt_reg <= 1'b0;
    end else if (sg_s2_reg) begin
      dip_cnt_reg <= 8'h00;
      sg_filt_reg <= 1'b1;
    end else if (dip_cnt_reg >= DIP_N) begin
      sg_filt_reg <= 1'b0;
    end else begin
      dip_cnt_reg <= dip_cnt_reg + 8'h01;
    end
  end

  // Manual reset filter: low must exceed 100 ns to count
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mr_cnt_reg <= 8'h00;
      pin_filt_reg <= 1'b1;
      pin_filt_d_reg <= 1'b1;
    end else begin
      pin_filt_d_reg <= pin_filt_reg;
      if (pin_s2_reg) begin
        mr_cnt_reg <= 8'h00;
        pin_filt_reg <= 1'b1;
      end else if (mr_cnt_reg >= MR_N) begin
        pin_filt_reg <= 1'b0;
      end else begin
        mr_cnt_reg <= mr_cnt_reg + 8'h01;
      end
    end
  end

  // Falling edge of filtered pin, active-low variant only, ignored while self-driven
  assign mr_edge = (ACTIVE_LOW != 0) && pin_filt_d_reg && !pin_filt_reg && state_reg == ST_RUN;

  // Reset sequencer
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_HOLD;
      to_cnt_reg <= {CW{1'b0}};
    end else begin
      case (state_reg)
        ST_HOLD: begin
          to_cnt_reg <= {CW{1'b0}};
          if (sg_filt_reg)
            state_reg <= ST_TIMEOUT;
        end
        ST_TIMEOUT: begin
          if (!sg_filt_reg) begin
            state_reg <= ST_HOLD;
          end else if (to_cnt_reg >= TO_LAST) begin
            state_reg <= ST_RUN;
          end else begin
            to_cnt_reg <= to_cnt_reg + {{(CW-1){1'b0}}, 1'b1};
          end
        end
        ST_RUN: begin
          to_cnt_reg <= {CW{1'b0}};
          if (!sg_filt_reg)
            state_reg <= ST_HOLD;
          else if (mr_edge)
            state_reg <= ST_TIMEOUT;
        end
        default: begin
          state_reg <= ST_HOLD;
          to_cnt_reg <= {CW{1'b0}};
        end
      endcase
    end
  end

  // Reset is active everywhere except in run
  always @* begin
    rst_act = (state_reg != ST_RUN);
  end

  // Program cycle timer: starts only out of reset, runs to end regardless
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prog_busy <= 1'b0;
      pg_cnt_reg <= {CW{1'b0}};
    end else if (prog_busy) begin
      if (pg_cnt_reg >= PG_LAST) begin
        prog_busy <= 1'b0;
        pg_cnt_reg <= {CW{1'b0}};
      end else begin
        pg_cnt_reg <= pg_cnt_reg + {{(CW-1){1'b0}}, 1'b1};
      end
    end else if (prog_start_req && !rst_act) begin
      prog_busy <= 1'b1;
    end
  end

  // Registered outputs: pin drive, memory gating, abort
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reset_pin_out <= (ACTIVE_LOW != 0) ? 1'b0 : 1'b1;
      reset_pin_oe_n <= 1'b0;
      mem_enable <= 1'b0;
      bus_abort <= 1'b0;
      bus_disable <= 1'b1;
      sys_reset_active <= 1'b1;
    end else begin
      reset_pin_out <= (ACTIVE_LOW != 0) ? 1'b0 : 1'b1;
      reset_pin_oe_n <= !rst_act;
      mem_enable <= !rst_act;
      bus_abort <= rst_act && bus_active;
      bus_disable <= rst_act || prog_busy || (prog_start_req && !rst_act);
      sys_reset_active <= rst_act;
    end
  end

endmodule // srs_supervisor
`default_nettype wire

// [dv/srs_chk.sv]
// Assertion checker for the supply reset supervisor
`timescale 1ns/1ps
`default_nettype none
module srs_chk #(parameter TIMEOUT_CYC = 200, parameter PROG_CYC = 50) (
  // Clock, reset, inputs
  input wire clk,
  input wire rst_n,
  input wire supply_good,
  input wire bus_active,
  // Outputs
  input wire reset_pin_oe_n,
  input wire mem_enable,
  input wire bus_abort,
  input wire prog_busy,
  input wire bus_disable,
  input wire sys_reset_active
);
  int unsigned rcnt;
  int unsigned pcnt;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Reset cycles with supply good, and busy cycles
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rcnt <= 0;
      pcnt <= 0;
    end else begin
      rcnt <= (sys_reset_active && supply_good) ? rcnt + 1 : 0;
      pcnt <= prog_busy ? pcnt + 1 : 0;
    end
  end
  AST_BROWNOUT: assert property (!supply_good [*8] |-> !reset_pin_oe_n) else $error("no reset on low supply");
  AST_DIP: assert property (!sys_reset_active && supply_good ##1 !supply_good ##1 supply_good [*8]
    |-> !sys_reset_active) else $error("short dip gave reset");
  AST_PIN: assert property (sys_reset_active == !reset_pin_oe_n) else $error("pin drive mismatch");
  AST_MEM_OFF: assert property (sys_reset_active |-> !mem_enable) else $error("memory on in reset");
  AST_ABORT: assert property (sys_reset_active && bus_active |=> bus_abort) else $error("no abort");
  AST_TO_MIN: assert property ($fell(sys_reset_active) |-> rcnt >= TIMEOUT_CYC) else $error("timeout short");
  AST_TO_MAX: assert property (rcnt <= TIMEOUT_CYC + 10) else $error("timeout long");
  AST_NO_PROG: assert property (sys_reset_active && !prog_busy |=> !prog_busy) else $error("prog in reset");
  AST_PROG_LEN: assert property ($fell(prog_busy) |-> pcnt == PROG_CYC) else $error("prog length");
  AST_BUS_OFF: assert property (prog_busy |-> bus_disable) else $error("bus on in prog");
endmodule // srs_chk
bind srs_supervisor srs_chk #(.TIMEOUT_CYC(TIMEOUT_CYC), .PROG_CYC(PROG_CYC)) u_chk (.clk(clk), .rst_n(rst_n),
  .supply_good(supply_good), .bus_active(bus_active), .reset_pin_oe_n(reset_pin_oe_n), .mem_enable(mem_enable),
  .bus_abort(bus_abort), .prog_busy(prog_busy), .bus_disable(bus_disable), .sys_reset_active(sys_reset_active));
`default_nettype wire

// [dv/srs_pin_model.sv]
// Reset pin wire with pull-up and push button
`timescale 1ns/1ps
`default_nettype none
module srs_pin_model (
  // Device drive and button
  input wire logic drv_val,
  input wire logic oe_n,
  input wire logic btn,
  // Wire level
  output logic pin
);
  // Button or device pull low, else the pull-up wins
  assign pin = btn ? 1'b0 : (!oe_n ? drv_val : 1'b1);
endmodule // srs_pin_model
`default_nettype wire

// [dv/srs_supervisor_tb.sv]
// Testbench for the supply reset supervisor
`timescale 1ns/1ps
`default_nettype none
module srs_supervisor_tb;
  logic clk = 0, rst_n = 0, supply_good = 0, btn = 0, prog_start_req = 0, bus_active = 0;
  logic pin, drv, oe_n, mem_enable, bus_abort, prog_busy, bus_disable, sys_reset_active;
  int fails = 0, n_tests = 0, cycles = 0;
  srs_pin_model u_pin (.drv_val(drv), .oe_n(oe_n), .btn(btn), .pin(pin));
  srs_supervisor #(.TIMEOUT_CYC(200), .PROG_CYC(50)) dut (.clk(clk), .rst_n(rst_n), .supply_good(supply_good),
    .reset_pin_in(pin), .reset_pin_out(drv), .reset_pin_oe_n(oe_n), .prog_start_req(prog_start_req),
    .bus_active(bus_active), .mem_enable(mem_enable), .bus_abort(bus_abort), .prog_busy(prog_busy),
    .bus_disable(bus_disable), .sys_reset_active(sys_reset_active));
  // Clock and hang guard
  always #12.5 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      fails++;
      finish_test();
    end
  end
  task automatic chk(input string name, input logic exp, input logic got);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %s exp %b got %b", name, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Bounded wait for the end of a reset
  task automatic wait_rel();
    repeat (400) if (sys_reset_active !== 1'b0) @(posedge clk);
    #1 chk("released", 1'b1, oe_n);
    chk("mem_enable", 1'b1, mem_enable);
    chk("bus_disable", 1'b0, bus_disable);
    chk("drive level", 1'b0, drv);
  endtask
  task automatic t_power();
    supply_good <= 1;
    cyc(180);
    #1 chk("held", 1'b1, sys_reset_active);
    wait_rel();
  endtask
  task automatic t_manual();
    @(posedge clk) supply_good <= 0;
    @(posedge clk) supply_good <= 1;
    cyc(10);
    #1 chk("dip", 1'b0, sys_reset_active);
    @(posedge clk) btn <= 1;
    cyc(2);
    btn <= 0;
    cyc(12);
    #1 chk("glitch", 1'b0, sys_reset_active);
    @(posedge clk) btn <= 1;
    cyc(10);
    btn <= 0;
    cyc(12);
    #1 chk("manual", 1'b0, oe_n);
    cyc(150);
    #1 chk("manual held", 1'b1, sys_reset_active);
    wait_rel();
  endtask
  // Host starts a program cycle after the manual reset ended, then requests another during a brownout reset
  task automatic t_prog();
    @(posedge clk) prog_start_req <= 1;
    @(posedge clk) prog_start_req <= 0;
    cyc(5);
    #1 chk("bus off in prog", 1'b1, bus_disable);
    @(posedge clk) supply_good <= 0;
    bus_active <= 1;
    cyc(12);
    #1 chk("brownout", 1'b0, oe_n);
    chk("busy kept", 1'b1, prog_busy);
    chk("abort", 1'b1, bus_abort);
    chk("mem off", 1'b0, mem_enable);
    @(posedge clk) prog_start_req <= 1;
    cyc(50);
    #1 chk("no start", 1'b0, prog_busy);
    @(posedge clk) prog_start_req <= 0;
    supply_good <= 1;
    bus_active <= 0;
    wait_rel();
  endtask
  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Main sequence
  initial begin
    cyc(5);
    rst_n <= 1;
    cyc(3);
    t_power();
    t_manual();
    t_prog();
    finish_test();
  end
endmodule // srs_supervisor_tb
`default_nettype wire
